// *** verilog/scan_tap_defines.svh ***
// constants for the pin-ring scan test port
// How it works
// - instruction 3, skip 1, identity 32 bits
// - 109 ring cells; cell 108 internal control
// - code 000 captures ring, connects chain
// - code 001 loads identity, selects it
// - code 010 captures ring, floats memory outputs
// - code 100 captures ring, connects chain
// - code 111 selects single skip bit
// - identity 31:29 version, 28:12 part code
// - identity 11:1 hardwired vendor code
// - identity bit 0 always one
// - tms and tdi sampled on rising tck
// - tdo changes only after falling tck
// - reset selects identity, control cell high
// - capture-ir loads 01 into low bits
// - under code 000 cell 108 gates outputs
// - top cell at tdi, cell 0 at tdo
`ifndef SCAN_TAP_DEFINES_SVH
`define SCAN_TAP_DEFINES_SVH
`define IR_LEN        3
`define RING_LEN      109
`define RING_CTL_BIT  108
`define ID_LEN        32
`define OP_EXT        3'h0
`define OP_IDENT      3'h1
`define OP_FLOAT      3'h2
`define OP_SNAP       3'h4
`define OP_SKIP       3'h7
`define IR_CAPTURE    3'h1
`define ID_VERSION    3'h0
`define ID_PART       17'h00a5a // arbitrary part code
`define ID_VENDOR     11'h05a   // arbitrary vendor code
`define FIFO_DEPTH    32
`endif

// *** verilog/scan_tap_pkg.sv ***
// types for the pin-ring scan test port
`default_nettype none
package scan_tap_pkg;
	typedef enum logic [3:0] {
		ST_RESET   = 4'h0,
		ST_IDLE    = 4'h1,
		ST_SEL_DR  = 4'h2,
		ST_CAP_DR  = 4'h3,
		ST_SHF_DR  = 4'h4,
		ST_EX1_DR  = 4'h5,
		ST_PAU_DR  = 4'h6,
		ST_EX2_DR  = 4'h7,
		ST_UPD_DR  = 4'h8,
		ST_SEL_IR  = 4'h9,
		ST_CAP_IR  = 4'ha,
		ST_SHF_IR  = 4'hb,
		ST_EX1_IR  = 4'hc,
		ST_PAU_IR  = 4'hd,
		ST_EX2_IR  = 4'he,
		ST_UPD_IR  = 4'hf
	} tap_state_t;
endpackage
`default_nettype wire

// *** verilog/pin_sync.sv ***
// two-stage synchroniser for a group of pin levels
`include "scan_tap_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_nxt;

	always_comb
	begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_r   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r   <= meta_nxt;
			sync_out <= sync_nxt;
		end
	end
endmodule
`default_nettype wire

// *** verilog/snap_fifo.sv ***
// snapshot fifo with valid/ready on both sides
`include "scan_tap_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module snap_fifo #(
	parameter int W = 109,
	parameter int D = 32
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]   cnt_r, cnt_nxt;
	logic          push, pop;

	always_comb
	begin
		in_ready  = (cnt_r != D[AW:0]);
		out_valid = (cnt_r != '0);
		out_data  = mem[rp_r];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wp_nxt    = push ? wp_r + 1'b1 : wp_r;
		rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt   = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_r] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule
`default_nettype wire

// *** verilog/scan_tap.sv ***
// test access port with pin-ring chain, identity and skip registers
`include "scan_tap_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module scan_tap
	import scan_tap_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// test pins
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 tdi,
	output logic                      tdo,
	output logic                      tdo_oe,
	// pin ring
	input  wire logic [`RING_LEN-1:0] ring_in,
	output logic      [`RING_LEN-1:0] ring_out,
	output logic                      ring_drive,
	output logic                      mem_out_en,
	// snapshot stream
	output logic                      snap_valid,
	input  wire logic                 snap_ready,
	output logic      [`RING_LEN-1:0] snap_data
);
	// ***************************************
	// pin synchronisation and tck edges
	// ***************************************
	logic [2:0] pins_s;
	logic       tck_s, tms_s, tdi_s;
	logic       tck_d_r, tck_d_nxt;
	logic       rise, fall;

	pin_sync #(.W(3)) u_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in ({tck, tms, tdi}),
		.sync_out (pins_s)
	);

	always_comb
	begin
		tck_s     = pins_s[2];
		tms_s     = pins_s[1];
		tdi_s     = pins_s[0];
		tck_d_nxt = tck_s;
		rise      = tck_s && !tck_d_r;
		fall      = !tck_s && tck_d_r;
	end

	// ***************************************
	// controller state machine
	// ***************************************
	tap_state_t st_r, st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (rise)
		begin
			case (st_r)
				ST_RESET:  st_nxt = tms_s ? ST_RESET  : ST_IDLE;
				ST_IDLE:   st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
				ST_SEL_DR: st_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
				ST_CAP_DR: st_nxt = tms_s ? ST_EX1_DR : ST_SHF_DR;
				ST_SHF_DR: st_nxt = tms_s ? ST_EX1_DR : ST_SHF_DR;
				ST_EX1_DR: st_nxt = tms_s ? ST_UPD_DR : ST_PAU_DR;
				ST_PAU_DR: st_nxt = tms_s ? ST_EX2_DR : ST_PAU_DR;
				ST_EX2_DR: st_nxt = tms_s ? ST_UPD_DR : ST_SHF_DR;
				ST_UPD_DR: st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
				ST_SEL_IR: st_nxt = tms_s ? ST_RESET  : ST_CAP_IR;
				ST_CAP_IR: st_nxt = tms_s ? ST_EX1_IR : ST_SHF_IR;
				ST_SHF_IR: st_nxt = tms_s ? ST_EX1_IR : ST_SHF_IR;
				ST_EX1_IR: st_nxt = tms_s ? ST_UPD_IR : ST_PAU_IR;
				ST_PAU_IR: st_nxt = tms_s ? ST_EX2_IR : ST_PAU_IR;
				ST_EX2_IR: st_nxt = tms_s ? ST_UPD_IR : ST_SHF_IR;
				ST_UPD_IR: st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
				default:   st_nxt = ST_RESET;
			endcase
		end
	end

	// ***************************************
	// scan registers
	// ***************************************
	logic [`IR_LEN-1:0]   ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
	logic                 skip_r, skip_nxt;
	logic [`ID_LEN-1:0]   id_r, id_nxt;
	logic [`RING_LEN-1:0] ring_sh_r, ring_sh_nxt, ring_lat_r, ring_lat_nxt;
	logic [`ID_LEN-1:0]   id_value;
	logic                 ring_sel;
	logic                 tdo_nxt, tdo_oe_nxt;
	logic                 ring_drive_nxt, mem_out_en_nxt;
	logic                 snap_push, snap_in_ready;

	// codes that put the pin-ring chain on the serial path
	function automatic logic ring_op(input logic [`IR_LEN-1:0] op);
		ring_op = (op == `OP_EXT) || (op == `OP_FLOAT) || (op == `OP_SNAP);
	endfunction

	always_comb
	begin
		id_value = {`ID_VERSION, `ID_PART, `ID_VENDOR, 1'b1};
		ring_sel = ring_op(ir_r);
		ir_sh_nxt    = ir_sh_r;
		ir_nxt       = ir_r;
		skip_nxt     = skip_r;
		id_nxt       = id_r;
		ring_sh_nxt  = ring_sh_r;
		ring_lat_nxt = ring_lat_r;
		snap_push    = 1'b0;
		if (rise)
		begin
			case (st_r)
				ST_RESET:
				begin
					ir_nxt = `OP_IDENT;
					ring_lat_nxt[`RING_CTL_BIT] = 1'b1;
				end
				ST_CAP_IR: ir_sh_nxt = {ir_r[2], 2'b01};
				ST_SHF_IR: ir_sh_nxt = {tdi_s, ir_sh_r[`IR_LEN-1:1]};
				ST_UPD_IR: ir_nxt = ir_sh_r;
				ST_CAP_DR:
				begin
					if (ir_r == `OP_IDENT)
						id_nxt = id_value;
					else if (ring_sel)
					begin
						ring_sh_nxt = ring_in;
						snap_push   = 1'b1;
					end
					else
						skip_nxt = 1'b0;
				end
				ST_SHF_DR:
				begin
					if (ir_r == `OP_IDENT)
						id_nxt = {tdi_s, id_r[`ID_LEN-1:1]};
					else if (ring_sel)
						ring_sh_nxt = {tdi_s, ring_sh_r[`RING_LEN-1:1]};
					else
						skip_nxt = tdi_s;
				end
				ST_UPD_DR: if (ring_sel) ring_lat_nxt = ring_sh_r;
				default: ;
			endcase
		end
		tdo_nxt    = tdo;
		tdo_oe_nxt = tdo_oe;
		if (fall)
		begin
			tdo_oe_nxt = (st_r == ST_SHF_IR) || (st_r == ST_SHF_DR);
			if (st_r == ST_SHF_IR)
				tdo_nxt = ir_sh_r[0];
			else if (ir_r == `OP_IDENT)
				tdo_nxt = id_r[0];
			else if (ring_sel)
				tdo_nxt = ring_sh_r[0];
			else
				tdo_nxt = skip_r;
		end
		ring_drive_nxt = (ir_r == `OP_EXT);
		mem_out_en_nxt = (ir_r == `OP_EXT) ? ring_lat_r[`RING_CTL_BIT]
			: (ir_r != `OP_FLOAT);
	end

	snap_fifo #(.W(`RING_LEN), .D(`FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (snap_push),
		.in_ready  (snap_in_ready),
		.in_data   (ring_in),
		.out_valid (snap_valid),
		.out_ready (snap_ready),
		.out_data  (snap_data)
	);

	// ***************************************
	// registers
	// ***************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tck_d_r    <= 1'b0;
			st_r       <= ST_RESET;
			ir_sh_r    <= '0;
			ir_r       <= `OP_IDENT;
			skip_r     <= 1'b0;
			id_r       <= '0;
			ring_sh_r  <= '0;
			ring_lat_r <= {1'b1, {(`RING_LEN-1){1'b0}}};
			tdo        <= 1'b0;
			tdo_oe     <= 1'b0;
			ring_drive <= 1'b0;
			mem_out_en <= 1'b1;
		end
		else
		begin
			tck_d_r    <= tck_d_nxt;
			st_r       <= st_nxt;
			ir_sh_r    <= ir_sh_nxt;
			ir_r       <= ir_nxt;
			skip_r     <= skip_nxt;
			id_r       <= id_nxt;
			ring_sh_r  <= ring_sh_nxt;
			ring_lat_r <= ring_lat_nxt;
			tdo        <= tdo_nxt;
			tdo_oe     <= tdo_oe_nxt;
			ring_drive <= ring_drive_nxt;
			mem_out_en <= mem_out_en_nxt;
		end
	end

	always_comb
	begin
		ring_out = ring_lat_r;
	end

	// ***************************************
	// checks
	// ***************************************
	sequence s_upd_ir;
		rise && st_r == ST_UPD_IR;
	endsequence

	chk_reset_ident: assert property (@(posedge clk) disable iff (!rst_b)
		rise && st_r == ST_RESET |=> ir_r == `OP_IDENT && ring_lat_r[`RING_CTL_BIT])
		else $error("reset did not restore identity instruction");
	chk_ir_update: assert property (@(posedge clk) disable iff (!rst_b)
		!(rise && st_r == ST_UPD_IR) && !(rise && st_r == ST_RESET) |=> $stable(ir_r))
		else $error("instruction changed outside update");
	chk_ir_load: assert property (@(posedge clk) disable iff (!rst_b)
		s_upd_ir |=> ir_r == $past(ir_sh_r))
		else $error("update did not load instruction");
	chk_cap_pattern: assert property (@(posedge clk) disable iff (!rst_b)
		rise && st_r == ST_CAP_IR |=> ir_sh_r[1:0] == 2'b01)
		else $error("capture-ir pattern wrong");
	chk_id_capture: assert property (@(posedge clk) disable iff (!rst_b)
		rise && st_r == ST_CAP_DR && ir_r == `OP_IDENT |=> id_r[0] && id_r == id_value)
		else $error("identity not captured");
	chk_tdo_fall: assert property (@(posedge clk) disable iff (!rst_b)
		!fall |=> $stable(tdo))
		else $error("tdo moved away from falling edge");
	chk_float_out: assert property (@(posedge clk) disable iff (!rst_b)
		ir_r == `OP_FLOAT |=> !mem_out_en)
		else $error("outputs not floated");
	chk_ext_ctl: assert property (@(posedge clk) disable iff (!rst_b)
		ir_r == `OP_EXT |=> mem_out_en == $past(ring_lat_r[`RING_CTL_BIT]))
		else $error("control cell not steering outputs");
	chk_tms_step: assert property (@(posedge clk) disable iff (!rst_b)
		rise && tms_s && st_r == ST_IDLE |=> st_r == ST_SEL_DR)
		else $error("state step wrong");
	chk_ring_shift: assert property (@(posedge clk) disable iff (!rst_b)
		rise && st_r == ST_SHF_DR && ring_sel |=> ring_sh_r[`RING_LEN-1] == $past(tdi_s))
		else $error("tdi not entering top cell");

	// data and instruction register paths, output controls, snapshot queue and state steps
	chk_skip_capture: assert property (@(posedge clk) disable iff (!rst_b)
		rise && st_r == ST_CAP_DR && ir_r == `OP_SKIP |=> !skip_r)
		else $error("skip bit not cleared at capture");
	chk_skip_shift: assert property (@(posedge clk) disable iff (!rst_b)
		rise && st_r == ST_SHF_DR && ir_r == `OP_SKIP |=> skip_r == $past(tdi_s))
		else $error("skip bit not loaded from tdi");
	chk_ring_capture: assert property (@(posedge clk) disable iff (!rst_b)
		rise && st_r == ST_CAP_DR && ring_op(ir_r) |=> ring_sh_r == $past(ring_in))
		else $error("pin ring not captured");
	chk_ring_update: assert property (@(posedge clk) disable iff (!rst_b)
		rise && st_r == ST_UPD_DR && ring_sel |=> ring_out == $past(ring_sh_r))
		else $error("ring latch not updated");
	chk_ext_drive: assert property (@(posedge clk) disable iff (!rst_b)
		ir_r == `OP_EXT |=> ring_drive)
		else $error("ring not driven under external test");
	chk_idle_drive: assert property (@(posedge clk) disable iff (!rst_b)
		ir_r != `OP_EXT |=> !ring_drive)
		else $error("ring driven outside external test");
	chk_quiet_out: assert property (@(posedge clk) disable iff (!rst_b)
		ir_r != `OP_EXT && ir_r != `OP_FLOAT |=> mem_out_en)
		else $error("memory outputs disturbed");
	chk_id_shift: assert property (@(posedge clk) disable iff (!rst_b)
		rise && st_r == ST_SHF_DR && ir_r == `OP_IDENT |=> id_r[`ID_LEN-1] == $past(tdi_s))
		else $error("identity shift wrong");
	chk_ir_shift: assert property (@(posedge clk) disable iff (!rst_b)
		rise && st_r == ST_SHF_IR |=> ir_sh_r[`IR_LEN-1] == $past(tdi_s))
		else $error("instruction shift wrong");
	chk_oe_shift: assert property (@(posedge clk) disable iff (!rst_b)
		fall |=> tdo_oe == ($past(st_r) == ST_SHF_IR || $past(st_r) == ST_SHF_DR))
		else $error("tdo enable wrong");
	chk_tdo_ring: assert property (@(posedge clk) disable iff (!rst_b)
		fall && st_r == ST_SHF_DR && ring_sel |=> tdo == $past(ring_sh_r[0]))
		else $error("cell 0 not at tdo");
	chk_snap_push: assert property (@(posedge clk) disable iff (!rst_b)
		snap_push && snap_in_ready |=> snap_valid)
		else $error("snapshot not queued");
	chk_sel_ir_exit: assert property (@(posedge clk) disable iff (!rst_b)
		rise && tms_s && st_r == ST_SEL_IR |=> st_r == ST_RESET)
		else $error("select-ir exit wrong");
	chk_tap_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!rise |=> $stable(st_r))
		else $error("state moved without tck rise");
endmodule
`default_nettype wire

// *** dv/scan_ctrl_model.sv ***
// test controller model: drives tck, tms, tdi and reads tdo
`timescale 1ns/1ns
`default_nettype none
module scan_ctrl_model (
	// clock
	input  wire logic         clk,
	// test pins
	output var logic          tck,
	output var logic          tms,
	output var logic          tdi,
	input  wire logic         tdo,
	// shifted-out word
	output var logic          res_stb,
	output var logic  [108:0] res_data
);
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		res_stb = 1'b0;
		res_data = '0;
	end
	// one tck period; tck stands low between frames
	task automatic tick(input logic m, input logic b, output logic q);
		@(posedge clk) #1;
		tms = m;
		tdi = b;
		repeat (8) @(posedge clk);
		#1 tck = 1'b1;
		q = tdo;
		repeat (8) @(posedge clk);
		#1 tck = 1'b0;
	endtask
	task automatic walk(input logic m);
		logic q;
		tick(m, 1'b0, q);
	endtask
	task automatic tlr();
		repeat (5) walk(1'b1);
		walk(1'b0);
	endtask
	// capture, shift n bits lsb first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [108:0] din);
		logic q;
		walk(1'b1);
		if (ir)
			walk(1'b1);
		walk(1'b0);
		walk(1'b0);
		res_data = '0;
		for (int k = 0; k < n; k++)
		begin
			tick(k == n - 1, din[k], q);
			res_data[k] = q;
		end
		walk(1'b1);
		walk(1'b0);
		tdi = ~tdi;
		@(posedge clk) #1 res_stb = 1'b1;
		@(posedge clk) #1 res_stb = 1'b0;
	endtask
endmodule
`default_nettype wire

// *** dv/scan_tap_test.sv ***
// self-checking bench for the scan test port
`include "scan_tap_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module scan_tap_test;
	// ****************
	// signals
	// ****************
	logic         clk = 1'b0;
	logic         rst_b;
	logic         tck, tms, tdi, tdo, tdo_oe;
	logic         ring_drive, mem_out_en, snap_valid, snap_ready, res_stb;
	logic [108:0] ring_in, ring_out, snap_data, res_data, d, lat;
	logic [108:0] exp_q[$], msk_q[$], snap_q[$];
	int           mismatches = 0, compares = 0, cyc = 0, oe_hits = 0, oe_exp = 0;
	localparam logic [108:0] id_word = {77'h0, `ID_VERSION, `ID_PART, `ID_VENDOR, 1'b1};
	localparam logic [108:0] id_msk = {77'h0, 32'hffffffff};
	localparam logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h0, 3'h4, 3'h7};
	always #5 clk = ~clk;
	scan_tap DUT (.clk, .rst_b, .tck, .tms, .tdi, .tdo, .tdo_oe, .ring_in, .ring_out,
		.ring_drive, .mem_out_en, .snap_valid, .snap_ready, .snap_data);
	scan_ctrl_model tap (.clk, .tck, .tms, .tdi, .tdo, .res_stb, .res_data);
	// tck rises that find tdo enabled
	always @(posedge tck)
	begin
		if (tdo_oe === 1'b1)
			oe_hits++;
	end
	// ****************
	// helpers
	// ****************
	task automatic check(input logic [108:0] got, input logic [108:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic expect_res(input logic [108:0] e, input logic [108:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
	endtask
	function automatic logic [108:0] rnd();
		logic [127:0] r;
		r = {$urandom(), $urandom(), $urandom(), $urandom()};
		return r[108:0];
	endfunction
	task automatic load_ir(input logic [2:0] c);
		expect_res(109'h1, 109'h3);
		oe_exp += 3;
		tap.scan(1'b1, 3, {106'h0, c});
	endtask
	task automatic dr_scan(input int n, input logic [108:0] v);
		oe_exp += n;
		tap.scan(1'b0, n, v);
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// results leave the queues oldest first
	always @(negedge clk)
	begin
		if (res_stb === 1'b1)
			check(res_data & msk_q.pop_front(), exp_q.pop_front());
		if (snap_valid === 1'b1 && snap_ready === 1'b1)
			check(snap_data, snap_q.pop_front());
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	// ****************
	// sequence
	// ****************
	initial
	begin
		void'($urandom(32'h7904));
		rst_b = 1'b0;
		snap_ready = 1'b0;
		ring_in = '0;
		repeat (20) @(posedge clk);
		#1 rst_b = 1'b1;
		@(posedge clk);
		check(109'(ring_out[108]), 109'h1);
		check(109'(mem_out_en), 109'h1);
		check(109'(tdo_oe), 109'h0);
		lat = {1'b1, 108'h0};
		tap.walk(1'b0);
		expect_res(id_word, id_msk);
		dr_scan(32, rnd());
		foreach (codes[i])
		begin
			load_ir(codes[i]);
			d = rnd();
			d[108] = i[0];
			@(posedge clk) #1 ring_in = rnd();
			if (codes[i] == 3'h1)
				expect_res(id_word, id_msk);
			else if (codes[i] inside {3'h0, 3'h2, 3'h4})
			begin
				expect_res(ring_in, '1);
				snap_q.push_back(ring_in);
				lat = d;
			end
			else
				expect_res({d[107:0], 1'b0}, '1);
			dr_scan(109, d);
			check(109'(mem_out_en), codes[i] == 3'h0 ? 109'(d[108]) : 109'(codes[i] != 3'h2));
			check(109'(ring_drive), 109'(codes[i] == 3'h0));
			check(ring_out, lat);
		end
		// fill the snapshot buffer past full, then drain it
		load_ir(3'h4);
		repeat (40)
		begin
			@(posedge clk) #1 ring_in = rnd();
			if (snap_q.size() < 32)
				snap_q.push_back(ring_in);
			expect_res(ring_in, 109'h1);
			dr_scan(1, rnd());
		end
		@(posedge clk) #1 snap_ready = 1'b1;
		for (int k = 0; k < 200 && snap_q.size() > 0; k++)
			@(posedge clk);
		repeat (2) @(posedge clk);
		check(109'(snap_q.size()), 109'h0);
		check(109'(snap_valid), 109'h0);
		load_ir(3'h7);
		tap.tlr();
		check(109'(ring_out[108]), 109'h1);
		expect_res(id_word, id_msk);
		dr_scan(32, rnd());
		repeat (20) @(posedge clk);
		check(109'(oe_hits), 109'(oe_exp));
		check(109'(exp_q.size()), 109'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
